/* File: rtl/bcs_pkg.sv */
// constants and types for the bus cycle status decoder
// assumes all monitored lines are already synchronous to i_clock
`default_nettype none
package bcs_pkg;
  // status word layout
  localparam int STATUS_W = 16;
  localparam int FIELD_W = 15;
  localparam int BIT_DATA_CONTROL = 0;
  localparam int BIT_MEMORY_IO = 1;
  localparam int BIT_WRITE_READ = 2;
  localparam int BIT_HOLD_ACK = 3;
  localparam int BIT_LANE_LSB = 4;
  localparam int LANE_W = 4;
  localparam int BIT_NARROW_BUS = 8;
  localparam int BIT_NEXT_ADDRESS = 9;
  localparam int BIT_BUS_LOCK = 10;
  localparam int BIT_COPRO_ERROR = 11;
  localparam int BIT_COPRO_OPERAND = 12;
  localparam int BIT_COPRO_BUSY = 13;
  localparam int BIT_CYCLE_START = 14;
  localparam int BIT_CYCLE_DONE = 15;
  localparam int COUNT_W = 16;

  // values after reset
  localparam logic [STATUS_W-1:0] STATUS_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

  // cycle type codes on status bits 2..0 (write/read, memory/io, data/control)
  localparam logic [2:0] CODE_INT_ACK = 3'h0;
  localparam logic [2:0] CODE_IO_READ = 3'h2;
  localparam logic [2:0] CODE_IO_WRITE = 3'h3;
  localparam logic [2:0] CODE_OPCODE_FETCH = 3'h4;
  localparam logic [2:0] CODE_HALT_SHUTDOWN = 3'h5;
  localparam logic [2:0] CODE_MEMORY_READ = 3'h6;
  localparam logic [2:0] CODE_MEMORY_WRITE = 3'h7;

  // lane pattern that marks a halt rather than a shutdown; plain default
  localparam logic [LANE_W-1:0] HALT_LANES_N = 4'hb;

  // byte lane patterns {lane3..lane0}, active low
  localparam logic [LANE_W-1:0] LANES_DOUBLE_WORD = 4'h0;
  localparam logic [LANE_W-1:0] LANES_HIGHER_3 = 4'h1;
  localparam logic [LANE_W-1:0] LANES_HIGH_WORD = 4'h3;
  localparam logic [LANE_W-1:0] LANES_BYTE_3 = 4'h7;
  localparam logic [LANE_W-1:0] LANES_LOWER_3 = 4'h8;
  localparam logic [LANE_W-1:0] LANES_MIDDLE_WORD = 4'h9;
  localparam logic [LANE_W-1:0] LANES_BYTE_2 = 4'hb;
  localparam logic [LANE_W-1:0] LANES_LOW_WORD = 4'hc;
  localparam logic [LANE_W-1:0] LANES_BYTE_1 = 4'hd;
  localparam logic [LANE_W-1:0] LANES_BYTE_0 = 4'he;

  typedef enum logic [8:0] {
    CT_INT_ACK = 9'h001,
    CT_IO_READ = 9'h002,
    CT_IO_WRITE = 9'h004,
    CT_OPCODE_FETCH = 9'h008,
    CT_HALT = 9'h010,
    CT_SHUTDOWN = 9'h020,
    CT_MEMORY_READ = 9'h040,
    CT_MEMORY_WRITE = 9'h080,
    CT_UNDEFINED = 9'h100
  } bcs_cycle_type_e;

  typedef enum logic [3:0] {
    LBL_DOUBLE_WORD = 4'h0,
    LBL_HIGHER_3 = 4'h1,
    LBL_HIGH_WORD = 4'h2,
    LBL_BYTE_3 = 4'h3,
    LBL_LOWER_3 = 4'h4,
    LBL_MIDDLE_WORD = 4'h5,
    LBL_BYTE_2 = 4'h6,
    LBL_LOW_WORD = 4'h7,
    LBL_BYTE_1 = 4'h8,
    LBL_BYTE_0 = 4'h9,
    LBL_OTHER = 4'ha
  } bcs_byte_validity_label_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACTIVE = 3'h2,
    ST_HELD = 3'h4
  } bcs_state_e;
endpackage
`default_nettype wire

/* File: rtl/bcs_type_decode.sv */
// combinational cycle type decoder
// assumes inputs are bits 2..0 and the lane enables of one status word
`default_nettype none
module bcs_type_decode (
  // cycle definition
  input wire logic i_data_control_flag,
  input wire logic i_memory_io_flag,
  input wire logic i_write_read_flag,
  input wire logic [bcs_pkg::LANE_W-1:0] i_byte_lane_enables_n,
  // decoded type
  output bcs_pkg::bcs_cycle_type_e o_cycle_type
);
  logic [2:0] code;

  always_comb begin
    code = {i_write_read_flag, i_memory_io_flag, i_data_control_flag};
    case (code)
      bcs_pkg::CODE_INT_ACK: o_cycle_type = bcs_pkg::CT_INT_ACK;
      bcs_pkg::CODE_IO_READ: o_cycle_type = bcs_pkg::CT_IO_READ;
      bcs_pkg::CODE_IO_WRITE: o_cycle_type = bcs_pkg::CT_IO_WRITE;
      bcs_pkg::CODE_OPCODE_FETCH: o_cycle_type = bcs_pkg::CT_OPCODE_FETCH;
      bcs_pkg::CODE_HALT_SHUTDOWN: begin
        // halt and shutdown share a code; lanes tell them apart
        if (i_byte_lane_enables_n == bcs_pkg::HALT_LANES_N) begin
          o_cycle_type = bcs_pkg::CT_HALT;
        end else begin
          o_cycle_type = bcs_pkg::CT_SHUTDOWN;
        end
      end
      bcs_pkg::CODE_MEMORY_READ: o_cycle_type = bcs_pkg::CT_MEMORY_READ;
      bcs_pkg::CODE_MEMORY_WRITE: o_cycle_type = bcs_pkg::CT_MEMORY_WRITE;
      default: o_cycle_type = bcs_pkg::CT_UNDEFINED;
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/bcs_lane_decode.sv */
// combinational byte validity decoder
// assumes the four active-low lane enables, lane 0 in bit 0
`default_nettype none
module bcs_lane_decode (
  // lane enables
  input wire logic [bcs_pkg::LANE_W-1:0] i_byte_lane_enables_n,
  // decoded label
  output bcs_pkg::bcs_byte_validity_label_e o_byte_validity_label
);
  always_comb begin
    case (i_byte_lane_enables_n)
      bcs_pkg::LANES_DOUBLE_WORD: o_byte_validity_label = bcs_pkg::LBL_DOUBLE_WORD;
      bcs_pkg::LANES_HIGHER_3: o_byte_validity_label = bcs_pkg::LBL_HIGHER_3;
      bcs_pkg::LANES_HIGH_WORD: o_byte_validity_label = bcs_pkg::LBL_HIGH_WORD;
      bcs_pkg::LANES_BYTE_3: o_byte_validity_label = bcs_pkg::LBL_BYTE_3;
      bcs_pkg::LANES_LOWER_3: o_byte_validity_label = bcs_pkg::LBL_LOWER_3;
      bcs_pkg::LANES_MIDDLE_WORD: o_byte_validity_label = bcs_pkg::LBL_MIDDLE_WORD;
      bcs_pkg::LANES_BYTE_2: o_byte_validity_label = bcs_pkg::LBL_BYTE_2;
      bcs_pkg::LANES_LOW_WORD: o_byte_validity_label = bcs_pkg::LBL_LOW_WORD;
      bcs_pkg::LANES_BYTE_1: o_byte_validity_label = bcs_pkg::LBL_BYTE_1;
      bcs_pkg::LANES_BYTE_0: o_byte_validity_label = bcs_pkg::LBL_BYTE_0;
      default: o_byte_validity_label = bcs_pkg::LBL_OTHER;
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/bcs_status_decoder.sv */
// bus cycle status monitor: packs the processor status lines into one word,
// captures one state per completed bus cycle and decodes type, lanes and size
// assumes every input is synchronous to i_clock, the processor clock rate
`default_nettype none

// Operation
// - bit 0 is the data/control flag, one for data cycles
// - bit 1 is the memory/io flag, one for memory accesses
// - bit 2 is the write/read flag, one for writes
// - bit 3 is hold acknowledge, high once the bus is given up
// - bits 4 to 7 are the active-low lane enables, lane 0 lowest
// - bit 9 is the active-low next-address request from the system
// - bit 10 is the active-low bus lock
// - bit 11 is the active-low coprocessor error
// - bit 12 is the active-high coprocessor operand request
// - bit 13 is the active-low coprocessor busy
// - bit 14 is the active-low cycle-start strobe
// - bit 15 is active-low cycle done, ignored during hold acknowledge
// - the trigger field gathers fifteen status lines
// - halt and shutdown cycles are told apart
// - cycle type comes from bits 2 to 0
// - valid bytes come from the four lane enables
// - bits 11 to 14 never affect type, lane or size decoding
module bcs_status_decoder (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // cycle definition
  input wire logic i_data_control_flag,
  input wire logic i_memory_io_flag,
  input wire logic i_write_read_flag,
  input wire logic i_hold_acknowledge,
  input wire logic [bcs_pkg::LANE_W-1:0] i_byte_lane_enables_n,
  // bus control
  input wire logic i_narrow_bus_request_n,
  input wire logic i_next_address_request_n,
  input wire logic i_bus_lock_n,
  input wire logic i_cycle_start_strobe_n,
  input wire logic i_cycle_done_n,
  // coprocessor handshake
  input wire logic i_copro_error_n,
  input wire logic i_copro_operand_request,
  input wire logic i_copro_busy_n,
  // live status
  output logic [bcs_pkg::STATUS_W-1:0] o_status_word,
  output logic [bcs_pkg::FIELD_W-1:0] o_status_field,
  // captured state
  output logic o_capture_valid,
  output logic [bcs_pkg::STATUS_W-1:0] o_captured_word,
  output bcs_pkg::bcs_cycle_type_e o_cycle_type,
  output bcs_pkg::bcs_byte_validity_label_e o_byte_validity_label,
  output logic o_size_32,
  output logic o_halt,
  output logic o_shutdown,
  output logic o_extra_cycle_due,
  // tracking
  output logic o_in_cycle,
  output logic o_bus_held,
  output logic [bcs_pkg::COUNT_W-1:0] o_cycle_count
);
  // packed status of this cycle
  logic [bcs_pkg::STATUS_W-1:0] status_now;
  logic capture_now;
  logic upper_lanes_on;
  bcs_pkg::bcs_cycle_type_e type_now;
  bcs_pkg::bcs_byte_validity_label_e label_now;

  // registered state
  logic [bcs_pkg::STATUS_W-1:0] status_word_ff;
  logic [bcs_pkg::STATUS_W-1:0] nxt_status_word;

  logic [bcs_pkg::STATUS_W-1:0] captured_word_ff;
  logic [bcs_pkg::STATUS_W-1:0] nxt_captured_word;
  logic capture_valid_ff;
  logic nxt_capture_valid;

  bcs_pkg::bcs_cycle_type_e cycle_type_ff;
  bcs_pkg::bcs_cycle_type_e nxt_cycle_type;
  bcs_pkg::bcs_byte_validity_label_e label_ff;
  bcs_pkg::bcs_byte_validity_label_e nxt_label;

  logic size_32_ff;
  logic nxt_size_32;
  logic extra_cycle_ff;
  logic nxt_extra_cycle;

  logic [bcs_pkg::COUNT_W-1:0] count_ff;
  logic [bcs_pkg::COUNT_W-1:0] nxt_count;

  bcs_pkg::bcs_state_e state_ff;
  bcs_pkg::bcs_state_e nxt_state;

  // pack the lines at their fixed positions
  always_comb begin
    status_now = bcs_pkg::STATUS_RESET;
    status_now[bcs_pkg::BIT_DATA_CONTROL] = i_data_control_flag;
    status_now[bcs_pkg::BIT_MEMORY_IO] = i_memory_io_flag;
    status_now[bcs_pkg::BIT_WRITE_READ] = i_write_read_flag;
    status_now[bcs_pkg::BIT_HOLD_ACK] = i_hold_acknowledge;
    status_now[bcs_pkg::BIT_LANE_LSB +: bcs_pkg::LANE_W] = i_byte_lane_enables_n;
    status_now[bcs_pkg::BIT_NARROW_BUS] = i_narrow_bus_request_n;
    status_now[bcs_pkg::BIT_NEXT_ADDRESS] = i_next_address_request_n;
    status_now[bcs_pkg::BIT_BUS_LOCK] = i_bus_lock_n;
    status_now[bcs_pkg::BIT_COPRO_ERROR] = i_copro_error_n;
    status_now[bcs_pkg::BIT_COPRO_OPERAND] = i_copro_operand_request;
    status_now[bcs_pkg::BIT_COPRO_BUSY] = i_copro_busy_n;
    status_now[bcs_pkg::BIT_CYCLE_START] = i_cycle_start_strobe_n;
    status_now[bcs_pkg::BIT_CYCLE_DONE] = i_cycle_done_n;
  end

  // decoders see only bits 2..0 and 7..4 of the word
  bcs_type_decode u_type_decode (
    .i_data_control_flag(status_now[bcs_pkg::BIT_DATA_CONTROL]),
    .i_memory_io_flag(status_now[bcs_pkg::BIT_MEMORY_IO]),
    .i_write_read_flag(status_now[bcs_pkg::BIT_WRITE_READ]),
    .i_byte_lane_enables_n(status_now[bcs_pkg::BIT_LANE_LSB +: bcs_pkg::LANE_W]),
    .o_cycle_type(type_now)
  );

  bcs_lane_decode u_lane_decode (
    .i_byte_lane_enables_n(status_now[bcs_pkg::BIT_LANE_LSB +: bcs_pkg::LANE_W]),
    .o_byte_validity_label(label_now)
  );

  // capture qualifier: done is disregarded while the bus is held
  always_comb begin
    capture_now = ~i_cycle_done_n & ~i_hold_acknowledge;
    upper_lanes_on = ~(&i_byte_lane_enables_n[bcs_pkg::LANE_W-1 -: 2]);
  end

  // live status word, refreshed on every rising edge
  always_comb begin
    nxt_status_word = status_now;
    if (i_reset) begin
      nxt_status_word = bcs_pkg::STATUS_RESET;
    end
  end

  always_ff @(posedge i_clock) begin
    status_word_ff <= nxt_status_word;
  end

  // one captured state per completed cycle
  always_comb begin
    nxt_capture_valid = capture_now;
    nxt_captured_word = captured_word_ff;
    if (capture_now) begin
      nxt_captured_word = status_now;
    end
    if (i_reset) begin
      nxt_capture_valid = 1'b0;
      nxt_captured_word = bcs_pkg::STATUS_RESET;
    end
  end

  always_ff @(posedge i_clock) begin
    capture_valid_ff <= nxt_capture_valid;
    captured_word_ff <= nxt_captured_word;
  end

  // decoded type and lanes hold until the next capture
  always_comb begin
    nxt_cycle_type = cycle_type_ff;
    nxt_label = label_ff;
    if (capture_now) begin
      nxt_cycle_type = type_now;
      nxt_label = label_now;
    end
    if (i_reset) begin
      nxt_cycle_type = bcs_pkg::CT_UNDEFINED;
      nxt_label = bcs_pkg::LBL_OTHER;
    end
  end

  always_ff @(posedge i_clock) begin
    cycle_type_ff <= nxt_cycle_type;
    label_ff <= nxt_label;
  end

  // transfer size and pending lane-shift cycle
  always_comb begin
    nxt_size_32 = size_32_ff;
    nxt_extra_cycle = extra_cycle_ff;
    if (capture_now) begin
      // narrow-bus request low marks a 16-bit transfer
      nxt_size_32 = status_now[bcs_pkg::BIT_NARROW_BUS];
      // a narrow cycle touching upper lanes is followed by a lane-shifted one
      nxt_extra_cycle = ~i_narrow_bus_request_n & upper_lanes_on;
    end
    if (i_reset) begin
      nxt_size_32 = 1'b0;
      nxt_extra_cycle = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    size_32_ff <= nxt_size_32;
    extra_cycle_ff <= nxt_extra_cycle;
  end

  // bus cycle tracking
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bcs_pkg::ST_IDLE: begin
        if (i_hold_acknowledge) begin
          nxt_state = bcs_pkg::ST_HELD;
        end else if (~i_cycle_start_strobe_n) begin
          nxt_state = bcs_pkg::ST_ACTIVE;
        end
      end
      bcs_pkg::ST_ACTIVE: begin
        // start low again at done is a pipelined next cycle, so stay active
        if (i_hold_acknowledge) begin
          nxt_state = bcs_pkg::ST_HELD;
        end else if (capture_now && i_cycle_start_strobe_n) begin
          nxt_state = bcs_pkg::ST_IDLE;
        end
      end
      bcs_pkg::ST_HELD: begin
        if (~i_hold_acknowledge) begin
          nxt_state = bcs_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = bcs_pkg::ST_IDLE;
      end
    endcase
    if (i_reset) begin
      nxt_state = bcs_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge i_clock) begin
    state_ff <= nxt_state;
  end

  // count of captured cycles, wraps
  always_comb begin
    nxt_count = count_ff;
    if (capture_now) begin
      nxt_count = count_ff + 16'h0001;
    end
    if (i_reset) begin
      nxt_count = bcs_pkg::COUNT_RESET;
    end
  end

  always_ff @(posedge i_clock) begin
    count_ff <= nxt_count;
  end

  // outputs straight from flops
  always_comb begin
    o_status_word = status_word_ff;
    o_status_field = status_word_ff[bcs_pkg::FIELD_W-1:0];
    o_capture_valid = capture_valid_ff;
    o_captured_word = captured_word_ff;
    o_cycle_type = cycle_type_ff;
    o_byte_validity_label = label_ff;
    o_size_32 = size_32_ff;
    o_halt = cycle_type_ff[4];
    o_shutdown = cycle_type_ff[5];
    o_extra_cycle_due = extra_cycle_ff;
    o_in_cycle = state_ff[1];
    o_bus_held = state_ff[2];
    o_cycle_count = count_ff;
  end
endmodule
`default_nettype wire

/* File: bench/bcs_status_checker.sv */
// assertions for the bus cycle status decoder
// assumes binding to bcs_status_decoder, one clock, synchronous reset
`default_nettype none
module bcs_status_checker (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // monitored lines
  input wire logic i_data_control_flag,
  input wire logic i_memory_io_flag,
  input wire logic i_write_read_flag,
  input wire logic i_hold_acknowledge,
  input wire logic [bcs_pkg::LANE_W-1:0] i_byte_lane_enables_n,
  input wire logic i_narrow_bus_request_n,
  input wire logic i_next_address_request_n,
  input wire logic i_bus_lock_n,
  input wire logic i_cycle_start_strobe_n,
  input wire logic i_cycle_done_n,
  input wire logic i_copro_error_n,
  input wire logic i_copro_operand_request,
  input wire logic i_copro_busy_n,
  // outputs under watch
  input wire logic [bcs_pkg::STATUS_W-1:0] o_status_word,
  input wire logic [bcs_pkg::FIELD_W-1:0] o_status_field,
  input wire logic o_capture_valid,
  input wire logic [bcs_pkg::STATUS_W-1:0] o_captured_word,
  input wire bcs_pkg::bcs_cycle_type_e o_cycle_type,
  input wire bcs_pkg::bcs_byte_validity_label_e o_byte_validity_label,
  input wire logic o_size_32,
  input wire logic o_halt,
  input wire logic o_shutdown,
  input wire logic o_extra_cycle_due,
  input wire logic o_in_cycle,
  input wire logic o_bus_held,
  input wire logic [bcs_pkg::COUNT_W-1:0] o_cycle_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] w;
  logic take;
  logic start_seen;
  logic end_seen;
  assign w = {i_cycle_done_n, i_cycle_start_strobe_n, i_copro_busy_n, i_copro_operand_request, i_copro_error_n,
    i_bus_lock_n, i_next_address_request_n, i_narrow_bus_request_n, i_byte_lane_enables_n, i_hold_acknowledge,
    i_write_read_flag, i_memory_io_flag, i_data_control_flag};
  assign take = !i_cycle_done_n && !i_hold_acknowledge;
  assign start_seen = !i_cycle_start_strobe_n && !i_hold_acknowledge && !o_bus_held;
  assign end_seen = o_in_cycle && take && i_cycle_start_strobe_n;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  a_low_byte: assert property (!$past(i_reset) |-> o_status_word[7:0] == $past(w[7:0]))
    else $error("status low byte differs from sampled lines");
  a_high_byte: assert property (!$past(i_reset) |-> o_status_word[15:8] == $past(w[15:8]))
    else $error("status high byte differs from sampled lines");
  a_field_gather: assert property (o_status_field == o_status_word[14:0])
    else $error("status field differs from status word");
  a_capture_pulse: assert property (!$past(i_reset) |-> o_capture_valid == $past(take))
    else $error("capture pulse not tied to done without hold");
  a_word_taken: assert property (o_capture_valid |-> o_captured_word == o_status_word)
    else $error("captured word differs from status word");
  a_count_step: assert property (!$past(i_reset) |-> o_cycle_count == $past(o_cycle_count) + 16'(o_capture_valid))
    else $error("cycle count step wrong");
  a_halt_split: assert property (o_capture_valid && o_captured_word[2:0] == 3'h5 |->
    o_halt == (o_captured_word[7:4] == bcs_pkg::HALT_LANES_N) && o_shutdown != o_halt)
    else $error("halt and shutdown not told apart");
  a_size_bit: assert property (o_capture_valid |-> o_size_32 == o_captured_word[8])
    else $error("size does not follow narrow request");
  a_extra_due: assert property (o_capture_valid |->
    o_extra_cycle_due == (!o_captured_word[8] && o_captured_word[7:6] != 2'h3))
    else $error("extra cycle flag wrong");
  a_decode_holds: assert property (!o_capture_valid && !$past(i_reset) |->
    $stable(o_cycle_type) && $stable(o_byte_validity_label))
    else $error("decode changed without capture");
  a_bus_held: assert property (!$past(i_reset) |-> o_bus_held == $past(i_hold_acknowledge))
    else $error("held state does not follow hold acknowledge");
  a_cycle_open: assert property (!$past(i_reset) && $past(start_seen) |-> o_in_cycle)
    else $error("cycle not tracked after start strobe");
  a_cycle_close: assert property (!$past(i_reset) && $past(end_seen) |-> !o_in_cycle)
    else $error("cycle still tracked after done");
  c_halt: cover property (o_halt);
  c_refused: cover property (!i_cycle_done_n && i_hold_acknowledge);
  c_back_to_back: cover property (o_capture_valid [*2]);
endmodule
bind bcs_status_decoder bcs_status_checker bcs_status_checker_i (.*);
`default_nettype wire

/* File: bench/bcs_cpu_model.sv */
// processor bus model: drives the status lines for whole bus cycles
// assumes lines packed in status word order, done low ends a cycle
`default_nettype none
module bcs_cpu_model (
  // clock
  input wire logic i_clock,
  // bus lines in status word order
  output logic [15:0] o_lines
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_lines = 16'heff0;
  task automatic run_cycle(input logic [2:0] c, input logic [3:0] lanes, input logic n16_n, input logic [4:0] s,
      input int waits);
    @(posedge i_clock);
    o_lines[2:0] <= c;
    o_lines[7:4] <= (c == 3'h4 && !n16_n) ? 4'hc : lanes;
    o_lines[13:8] <= {s, n16_n};
    o_lines[14] <= 1'b0;
    repeat (waits) @(posedge i_clock) o_lines[14] <= 1'b1;
    @(posedge i_clock);
    o_lines[15:14] <= 2'h1;
    @(posedge i_clock);
    o_lines[15] <= 1'b1;
    // released lines show the inverse, not the last value
    o_lines[7:0] <= ~o_lines[7:0] & 8'hf7;
  endtask
  task automatic bus_burst(input logic h, input int n);
    @(posedge i_clock);
    o_lines[3] <= h;
    o_lines[15] <= 1'b0;
    repeat (n) @(posedge i_clock);
    o_lines[15] <= 1'b1;
    o_lines[3] <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: bench/bcs_status_decoder_tb_top.sv */
// self-checking bench for the bus cycle status decoder
// assumes the processor model drives every monitored line
`default_nettype none
module bcs_status_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [2:0] c; logic [3:0] lanes; logic [8:0] ty; logic [3:0] lb;} bcs_row_s;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_data_control_flag, i_memory_io_flag, i_write_read_flag, i_hold_acknowledge, i_narrow_bus_request_n;
  logic i_next_address_request_n, i_bus_lock_n, i_cycle_start_strobe_n, i_cycle_done_n;
  logic i_copro_error_n, i_copro_operand_request, i_copro_busy_n;
  logic [3:0] i_byte_lane_enables_n;
  logic [15:0] o_status_word, o_captured_word, o_cycle_count, lines, base;
  logic [14:0] o_status_field;
  logic o_capture_valid, o_size_32, o_halt, o_shutdown, o_extra_cycle_due, o_in_cycle, o_bus_held;
  bcs_pkg::bcs_cycle_type_e o_cycle_type;
  bcs_pkg::bcs_byte_validity_label_e o_byte_validity_label;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  bcs_row_s rows [11] = '{'{3'h7, 4'h0, 9'h080, 4'h0}, '{3'h6, 4'h1, 9'h040, 4'h1}, '{3'h4, 4'h3, 9'h008, 4'h2},
    '{3'h3, 4'h7, 9'h004, 4'h3}, '{3'h2, 4'h8, 9'h002, 4'h4}, '{3'h0, 4'h9, 9'h001, 4'h5},
    '{3'h5, 4'hb, 9'h010, 4'h6}, '{3'h5, 4'hc, 9'h020, 4'h7}, '{3'h1, 4'hd, 9'h100, 4'h8},
    '{3'h7, 4'he, 9'h080, 4'h9}, '{3'h6, 4'h5, 9'h040, 4'ha}};
  assign {i_cycle_done_n, i_cycle_start_strobe_n, i_copro_busy_n, i_copro_operand_request, i_copro_error_n,
    i_bus_lock_n, i_next_address_request_n, i_narrow_bus_request_n, i_byte_lane_enables_n, i_hold_acknowledge,
    i_write_read_flag, i_memory_io_flag, i_data_control_flag} = lines;
  bcs_status_decoder bcs_status_decoder_i (.*);
  bcs_cpu_model bcs_cpu_model_i (.i_clock(i_clock), .o_lines(lines));
  initial forever #25 i_clock = ~i_clock;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("TB: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    #1;
    check(16'(o_cycle_type), 16'h0100);
    check(16'(o_byte_validity_label), 16'h000a);
    check(o_cycle_count, 16'h0000);
    check(o_status_word, 16'h0000);
    $display("TB: reset test done");
    // bits 9 to 13 vary per row and must not disturb decoding
    for (int i = 0; i < 11; i++) begin
      base = o_cycle_count;
      bcs_cpu_model_i.run_cycle(rows[i].c, rows[i].lanes, 1'b1, 5'(i * 7), i % 3);
      #1;
      check(16'(o_capture_valid), 16'h0001);
      check(16'(o_cycle_type), 16'(rows[i].ty));
      check(16'(o_byte_validity_label), 16'(rows[i].lb));
      check(16'(o_size_32), 16'h0001);
      check(o_cycle_count, base + 16'h0001);
      check(16'(o_in_cycle), 16'h0000);
      check(16'(o_captured_word[7:0]), 16'({rows[i].lanes, 1'b0, rows[i].c}));
      $display("TB: row %0d done", i);
    end
    bcs_cpu_model_i.run_cycle(3'h7, 4'h0, 1'b0, 5'h1f, 0);
    #1;
    check(16'({o_size_32, o_extra_cycle_due}), 16'h0001);
    bcs_cpu_model_i.run_cycle(3'h7, 4'hc, 1'b0, 5'h1f, 0);
    #1;
    check(16'({o_byte_validity_label, o_extra_cycle_due}), 16'h000e);
    bcs_cpu_model_i.run_cycle(3'h4, 4'h0, 1'b0, 5'h00, 1);
    #1;
    check(16'(o_byte_validity_label), 16'h0007);
    $display("TB: narrow bus test done");
    base = o_cycle_count;
    bcs_cpu_model_i.bus_burst(1'b0, 3);
    #1;
    check(o_cycle_count, base + 16'h0003);
    base = o_cycle_count;
    bcs_cpu_model_i.bus_burst(1'b1, 4);
    #1;
    check(16'({o_bus_held, o_capture_valid}), 16'h0002);
    check(o_cycle_count, base);
    $display("TB: burst and hold test done");
    @(posedge i_clock);
    i_reset <= 1'b1;
    @(posedge i_clock);
    i_reset <= 1'b0;
    #1;
    check(o_cycle_count, 16'h0000);
    $display("TB: second reset test done");
    test_done();
  end
endmodule
`default_nettype wire
